/* logic/aux_unit.sv */
`timescale 1ns/1ps
module aux_unit (
  input  wire logic               aclk,    // Clock
  input  wire logic               aresetn, // Sync reset, low
  input  timer_pkg::aux_cfg_s     cfg,     // Mode, run, dir, select
  input  timer_pkg::edge_s        ext,     // External input edges
  input  timer_pkg::edge_s        otl,     // Latch edges from overflow
  input  wire logic [9:0]         div,     // Shared prescale divider
  input  wire logic               wr_en,   // Software load
  input  wire logic               clr,     // Clear request
  input  wire logic [15:0]        wr_val,  // Software value
  input  wire logic [15:0]        cap_val, // Core value to capture
  output logic      [15:0]        value,   // Timer contents
  output logic                    trig,    // Reload or capture event
  output logic                    irq_set  // Flag set request
);
  timer_pkg::edge_s src;
  logic             src_ev;
  logic             cap_ev;
  logic             tick;
  logic             cnt;
  logic             wrap;

  always_comb begin
    src    = cfg.isel[2] ? otl : ext;
    src_ev = (cfg.isel[0] & src.rise) | (cfg.isel[1] & src.fall);
    cap_ev = (cfg.isel[0] & ext.rise) | (cfg.isel[1] & ext.fall);
    tick   = &(div | ~timer_pkg::pre_mask(cfg.isel));
    case (cfg.mode)
      timer_pkg::MODE_RELOAD:  trig = src_ev;
      timer_pkg::MODE_CAPTURE: trig = cap_ev;
      default:                 trig = 1'b0;
    endcase
    case (cfg.mode)
      timer_pkg::MODE_TIMER:   cnt = cfg.run & tick;
      timer_pkg::MODE_COUNTER: cnt = cfg.run & src_ev;
      default:                 cnt = 1'b0;
    endcase
    wrap    = cnt & (cfg.dir ? value == timer_pkg::RST_VAL : value == timer_pkg::CNT_MAX);
    irq_set = trig | wrap;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      value <= timer_pkg::RST_VAL;
    end else if (clr) begin
      value <= timer_pkg::RST_VAL;
    end else if (wr_en) begin
      value <= wr_val;
    end else if (cfg.mode == timer_pkg::MODE_CAPTURE && trig) begin
      value <= cap_val;
    end else if (cnt) begin
      value <= cfg.dir ? value - 16'h0001 : value + 16'h0001;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  aux_hold_a: assert property (
    (cfg.mode == timer_pkg::MODE_RELOAD || (cfg.mode == timer_pkg::MODE_CAPTURE && !trig)) && !wr_en && !clr
    |=> $stable(value)) else $error("Auxiliary timer moved while held");
  aux_capture_a: assert property (
    cfg.mode == timer_pkg::MODE_CAPTURE && trig && !wr_en && !clr
    |-> irq_set ##1 value == $past(cap_val)) else $error("Capture lost value or flag");
  aux_cap_c: cover property (cfg.mode == timer_pkg::MODE_CAPTURE && trig);

endmodule // aux_unit

/* logic/gp_timer_aux_core_modes.sv */
// Overview of operation
// - Both latch edges: aux counts every wrap
// - Single latch edge: aux counts every second
// - Mode 100 reloads core from aux
// - Reload trigger uses counter edge select
// - Reload mode stops aux counting
// - Reload loads core, sets aux flag
// - Latch-triggered reload also sets core flag
// - Software latch writes trigger nothing
// - Both edges reload each wrap, single alternate
// - Rise and fall aux alternate reloads
// - Latch reaches output only when enabled
// - Same trigger: second aux wins
// - Mode 101 captures core on input edge
// - Capture uses low two select bits
// - Capture mode stops aux counting
// - Capture sets aux flag with store
// - Core A inputs capture aux B
// - Core B runs while run bit set in timer mode
// - Core B direction bit, anytime change
// - Core B wrap toggles latch, overflow line
// - Core B timer mode prescaled clock
// - Edge select encoding of aux inputs
//
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module gp_timer_aux_core_modes (
  input  wire logic        aclk,                   // Clock, 50 MHz
  input  wire logic        aresetn,                // Sync reset, low
  input  wire logic        awvalid,                // AXI write address
  output logic             awready,                // AXI
  input  wire logic [7:0]  awaddr,                 // AXI
  input  wire logic        wvalid,                 // AXI write data
  output logic             wready,                 // AXI
  input  wire logic [31:0] wdata,                  // AXI
  input  wire logic [3:0]  wstrb,                  // AXI
  output logic             bvalid,                 // AXI write response
  input  wire logic        bready,                 // AXI
  output logic [1:0]       bresp,                  // AXI
  input  wire logic        arvalid,                // AXI read address
  output logic             arready,                // AXI
  input  wire logic [7:0]  araddr,                 // AXI
  output logic             rvalid,                 // AXI read data
  input  wire logic        rready,                 // AXI
  output logic [31:0]      rdata,                  // AXI
  output logic [1:0]       rresp,                  // AXI
  input  wire logic        aux_a1_input_line,      // Aux A1 trigger pin
  input  wire logic        aux_a2_input_line,      // Aux A2 trigger pin
  input  wire logic        core_a_count_input,     // Capture trigger pin
  input  wire logic        core_a_direction_input, // Capture trigger pin
  output logic             core_a_output_line,     // Gated toggle latch
  output logic             core_b_overflow_line    // Wrap pulse of core B
);
  logic [15:0] core_timer_a;
  logic [15:0] core_timer_b;
  logic [15:0] capture_reload_reg;
  logic [12:0] ctrl_a_reg;
  logic [12:0] ctrl_b_reg;
  logic [7:0]  cfg_reg [3];
  logic [4:0]  flags_reg;
  logic        core_a_toggle_latch;
  logic        core_b_toggle_latch;
  logic [9:0]  div_reg;
  logic [3:0]  pin_reg;
  logic [7:0]  aw_addr_reg;
  logic [7:0]  ar_addr_hold;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;

  logic        wr_fire;
  logic [31:0] wr_val;
  logic [32:0] wr_old;
  logic [32:0] rd_word;
  logic [4:0]  flag_set;
  logic [15:0] aux_val [3];
  logic [2:0]  aux_trig;
  logic [2:0]  aux_irq;
  logic [2:0]  aux_wr;
  logic        tick_a;
  logic        tick_b;
  logic        cnt_a;
  logic        cnt_b;
  logic        ovf_a;
  logic        ovf_b;
  logic        rl1;
  logic        rl2;
  logic        rl_otl;
  logic        cap_b;
  timer_pkg::edge_s otl_a_ev;
  timer_pkg::edge_s otl_b_ev;
  timer_pkg::edge_s ext_ev [3];

  // Register read mux, bit 32 marks a mapped address
  function automatic logic [32:0] reg_read(input logic [7:0] a);
    case (a)
      timer_pkg::OFF_CORE_A: reg_read = {1'b1, 16'h0000, core_timer_a};
      timer_pkg::OFF_AUX_A1: reg_read = {1'b1, 16'h0000, aux_val[0]};
      timer_pkg::OFF_AUX_A2: reg_read = {1'b1, 16'h0000, aux_val[1]};
      timer_pkg::OFF_CTRL_A: reg_read = {1'b1, 19'h00000, ctrl_a_reg[12:10], core_a_toggle_latch,
                                         ctrl_a_reg[8:0]};
      timer_pkg::OFF_CFG_A1: reg_read = {1'b1, 24'h000000, cfg_reg[0]};
      timer_pkg::OFF_CFG_A2: reg_read = {1'b1, 24'h000000, cfg_reg[1]};
      timer_pkg::OFF_FLAGS:  reg_read = {1'b1, 27'h0000000, flags_reg};
      timer_pkg::OFF_CORE_B: reg_read = {1'b1, 16'h0000, core_timer_b};
      timer_pkg::OFF_AUX_B:  reg_read = {1'b1, 16'h0000, aux_val[2]};
      timer_pkg::OFF_CAPTURE_RELOAD_REG: reg_read = {1'b1, 16'h0000, capture_reload_reg};
      timer_pkg::OFF_CTRL_B: reg_read = {1'b1, 19'h00000, ctrl_b_reg[12:10], core_b_toggle_latch,
                                         ctrl_b_reg[8:0]};
      timer_pkg::OFF_CFG_B:  reg_read = {1'b1, 24'h000000, cfg_reg[2]};
      default:               reg_read = {1'b0, 32'h00000000};
    endcase
  endfunction

  always_comb begin
    wr_fire = !awready && !wready && !bvalid;
    wr_old  = reg_read(aw_addr_reg);
    rd_word = reg_read(araddr);
    for (int i = 0; i < 4; i++) begin
      wr_val[i*8 +: 8] = w_strb_reg[i] ? w_data_reg[i*8 +: 8] : wr_old[i*8 +: 8];
    end
  end

  // Write address and data are taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready     <= 1'b1;
      wready      <= 1'b1;
      bvalid      <= 1'b0;
      bresp       <= timer_pkg::RESP_OK;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h00000000;
      w_strb_reg  <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        awready     <= 1'b0;
        aw_addr_reg <= awaddr;
      end
      if (wvalid && wready) begin
        wready     <= 1'b0;
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
      end
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp  <= wr_old[32] ? timer_pkg::RESP_OK : timer_pkg::RESP_ERR;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready      <= 1'b1;
      rvalid       <= 1'b0;
      rdata        <= 32'h00000000;
      rresp        <= timer_pkg::RESP_OK;
      ar_addr_hold <= 8'h00;
    end else if (arvalid && arready) begin
      arready      <= 1'b0;
      rvalid       <= 1'b1;
      ar_addr_hold <= araddr;
      rdata        <= rd_word[31:0];
      rresp        <= rd_word[32] ? timer_pkg::RESP_OK : timer_pkg::RESP_ERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  // Control registers; latch bits are held apart
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_a_reg <= 13'h0000;
      ctrl_b_reg <= 13'h0000;
      for (int i = 0; i < 3; i++) begin
        cfg_reg[i] <= 8'h00;
      end
    end else if (wr_fire) begin
      case (aw_addr_reg)
        timer_pkg::OFF_CTRL_A: ctrl_a_reg <= wr_val[12:0];
        timer_pkg::OFF_CTRL_B: ctrl_b_reg <= wr_val[12:0];
        timer_pkg::OFF_CFG_A1: cfg_reg[0] <= wr_val[7:0];
        timer_pkg::OFF_CFG_A2: cfg_reg[1] <= wr_val[7:0];
        timer_pkg::OFF_CFG_B:  cfg_reg[2] <= wr_val[7:0];
        default: ;
      endcase
    end
  end

  // Free divider shared by all prescalers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_reg <= 10'h000;
      pin_reg <= 4'h0;
    end else begin
      div_reg <= div_reg + 10'h001;
      pin_reg <= {core_a_direction_input, core_a_count_input, aux_a2_input_line, aux_a1_input_line};
    end
  end

  always_comb begin
    tick_a = &(div_reg | ~timer_pkg::pre_mask(ctrl_a_reg[timer_pkg::CTL_PRE_LSB +: 3]));
    tick_b = &(div_reg | ~timer_pkg::pre_mask(ctrl_b_reg[timer_pkg::CTL_PRE_LSB +: 3]));
    cnt_a  = ctrl_a_reg[timer_pkg::CTL_RUN] && tick_a;
    cnt_b  = ctrl_b_reg[timer_pkg::CTL_RUN] && tick_b
             && ctrl_b_reg[timer_pkg::CTL_MODE_LSB +: 3] == timer_pkg::MODE_TIMER;
    ovf_a  = cnt_a && (ctrl_a_reg[timer_pkg::CTL_DIR] ? core_timer_a == timer_pkg::RST_VAL
                                                      : core_timer_a == timer_pkg::CNT_MAX);
    ovf_b  = cnt_b && (ctrl_b_reg[timer_pkg::CTL_DIR] ? core_timer_b == timer_pkg::RST_VAL
                                                      : core_timer_b == timer_pkg::CNT_MAX);
    otl_a_ev = '{rise: ovf_a && !core_a_toggle_latch, fall: ovf_a && core_a_toggle_latch};
    otl_b_ev = '{rise: ovf_b && !core_b_toggle_latch, fall: ovf_b && core_b_toggle_latch};
    ext_ev[0] = '{rise: aux_a1_input_line && !pin_reg[0], fall: !aux_a1_input_line && pin_reg[0]};
    ext_ev[1] = '{rise: aux_a2_input_line && !pin_reg[1], fall: !aux_a2_input_line && pin_reg[1]};
    ext_ev[2] = '{rise: 1'b0, fall: 1'b0};
    // any transition on either core A input
    cap_b = ctrl_b_reg[timer_pkg::CTL_CAP_EN]
            && ((core_a_count_input ^ pin_reg[2]) || (core_a_direction_input ^ pin_reg[3]));
    rl1 = aux_trig[0] && cfg_reg[0][5:3] == timer_pkg::MODE_RELOAD;
    rl2 = aux_trig[1] && cfg_reg[1][5:3] == timer_pkg::MODE_RELOAD;
    rl_otl = (rl1 && cfg_reg[0][2]) || (rl2 && cfg_reg[1][2]);
    aux_wr[0] = wr_fire && aw_addr_reg == timer_pkg::OFF_AUX_A1;
    aux_wr[1] = wr_fire && aw_addr_reg == timer_pkg::OFF_AUX_A2;
    aux_wr[2] = wr_fire && aw_addr_reg == timer_pkg::OFF_AUX_B;
  end

  for (genvar g = 0; g < 3; g++) begin : g_aux
    aux_unit u_aux (
      .aclk    (aclk),
      .aresetn (aresetn),
      .cfg     (timer_pkg::aux_cfg_s'(cfg_reg[g])),
      .ext     (ext_ev[g]),
      .otl     (g == 2 ? otl_b_ev : otl_a_ev),
      .div     (div_reg),
      .wr_en   (aux_wr[g]),
      .clr     (g == 2 && cap_b && ctrl_b_reg[timer_pkg::CTL_CAP_CLR] && !aux_wr[g]),
      .wr_val  (wr_val[15:0]),
      .cap_val (core_timer_a),
      .value   (aux_val[g]),
      .trig    (aux_trig[g]),
      .irq_set (aux_irq[g])
    );
  end

  // core A reload, software write first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_timer_a <= timer_pkg::RST_VAL;
    end else if (wr_fire && aw_addr_reg == timer_pkg::OFF_CORE_A) begin
      core_timer_a <= wr_val[15:0];
    end else if (rl2) begin
      core_timer_a <= aux_val[1];
    end else if (rl1) begin
      core_timer_a <= aux_val[0];
    end else if (cnt_a) begin
      core_timer_a <= ctrl_a_reg[timer_pkg::CTL_DIR] ? core_timer_a - 16'h0001 : core_timer_a + 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_timer_b <= timer_pkg::RST_VAL;
    end else if (wr_fire && aw_addr_reg == timer_pkg::OFF_CORE_B) begin
      core_timer_b <= wr_val[15:0];
    end else if (cnt_b) begin
      core_timer_b <= ctrl_b_reg[timer_pkg::CTL_DIR] ? core_timer_b - 16'h0001 : core_timer_b + 16'h0001;
    end
  end

  // latch toggles on wrap, software may set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_a_toggle_latch <= 1'b0;
      core_b_toggle_latch <= 1'b0;
    end else begin
      if (wr_fire && aw_addr_reg == timer_pkg::OFF_CTRL_A) begin
        core_a_toggle_latch <= wr_val[timer_pkg::CTL_LATCH];
      end else if (ovf_a) begin
        core_a_toggle_latch <= !core_a_toggle_latch;
      end
      if (wr_fire && aw_addr_reg == timer_pkg::OFF_CTRL_B) begin
        core_b_toggle_latch <= wr_val[timer_pkg::CTL_LATCH];
      end else if (ovf_b) begin
        core_b_toggle_latch <= !core_b_toggle_latch;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capture_reload_reg <= timer_pkg::RST_VAL;
    end else if (wr_fire && aw_addr_reg == timer_pkg::OFF_CAPTURE_RELOAD_REG) begin
      capture_reload_reg <= wr_val[15:0];
    end else if (cap_b) begin
      capture_reload_reg <= aux_val[2];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_a_output_line   <= 1'b0;
      core_b_overflow_line <= 1'b0;
    end else begin
      core_a_output_line   <= ctrl_a_reg[timer_pkg::CTL_OE] && core_a_toggle_latch;
      core_b_overflow_line <= ovf_b;
    end
  end

  always_comb begin
    flag_set = '0;
    flag_set[timer_pkg::FLG_CORE_A] = ovf_a || rl_otl;
    flag_set[timer_pkg::FLG_AUX_A1] = aux_irq[0];
    flag_set[timer_pkg::FLG_AUX_A2] = aux_irq[1];
    flag_set[timer_pkg::FLG_CORE_B] = ovf_b;
    flag_set[timer_pkg::FLG_AUX_B]  = aux_irq[2];
  end

  // Write one clears; a same-cycle event still sets
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_reg <= 5'h00;
    end else if (wr_fire && aw_addr_reg == timer_pkg::OFF_FLAGS) begin
      flags_reg <= (flags_reg & ~wr_val[4:0]) | flag_set;
    end else begin
      flags_reg <= flags_reg | flag_set;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  reload_load_a: assert property (
    rl1 && !rl2 && !(wr_fire && aw_addr_reg == timer_pkg::OFF_CORE_A)
    |=> core_timer_a == $past(aux_val[0]) && flags_reg[timer_pkg::FLG_AUX_A1]) else $error("Reload from A1 failed");
  reload_prio_a: assert property (
    rl1 && rl2 && !(wr_fire && aw_addr_reg == timer_pkg::OFF_CORE_A)
    |=> core_timer_a == $past(aux_val[1])) else $error("Tie did not load from A2");
  otl_irq_a: assert property (
    rl_otl |=> flags_reg[timer_pkg::FLG_CORE_A]) else $error("Core flag missing on latch reload");
  sw_latch_a: assert property (
    rl_otl |-> ovf_a) else $error("Reload without core wrap");
  out_gate_a: assert property (
    ##1 core_a_output_line == $past(ctrl_a_reg[timer_pkg::CTL_OE] && core_a_toggle_latch))
    else $error("Output line not gated latch");
  run_stop_a: assert property (
    !ctrl_b_reg[timer_pkg::CTL_RUN] && !(wr_fire && aw_addr_reg == timer_pkg::OFF_CORE_B)
    |=> $stable(core_timer_b)) else $error("Core B moved while stopped");
  dir_up_a: assert property (
    cnt_b && !ctrl_b_reg[timer_pkg::CTL_DIR] && !(wr_fire && aw_addr_reg == timer_pkg::OFF_CORE_B)
    |=> core_timer_b == $past(core_timer_b) + 16'h0001) else $error("Core B did not count up");
  wrap_toggle_a: assert property (
    ovf_b && !(wr_fire && aw_addr_reg == timer_pkg::OFF_CTRL_B)
    |=> core_b_toggle_latch != $past(core_b_toggle_latch) && core_b_overflow_line
        && flags_reg[timer_pkg::FLG_CORE_B]) else $error("Core B wrap effects missing");
  capt_b_a: assert property (
    cap_b && !(wr_fire && aw_addr_reg == timer_pkg::OFF_CAPTURE_RELOAD_REG)
    |=> capture_reload_reg == $past(aux_val[2])) else $error("Aux B not captured");
  pwm_alt_c: cover property (rl1 ##[1:1000] rl2 ##[1:1000] rl1);
  ovf_b_c: cover property (ovf_b && ctrl_b_reg[timer_pkg::CTL_DIR]);
  cap_b_c: cover property (cap_b && ctrl_b_reg[timer_pkg::CTL_CAP_CLR]);

endmodule // gp_timer_aux_core_modes

/* logic/timer_pkg.sv */
package timer_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CORE_A  = 8'h00;
  localparam logic [7:0] OFF_AUX_A1  = 8'h04;
  localparam logic [7:0] OFF_AUX_A2  = 8'h08;
  localparam logic [7:0] OFF_CTRL_A  = 8'h0c;
  localparam logic [7:0] OFF_CFG_A1  = 8'h10;
  localparam logic [7:0] OFF_CFG_A2  = 8'h14;
  localparam logic [7:0] OFF_FLAGS   = 8'h18;
  localparam logic [7:0] OFF_CORE_B  = 8'h1c;
  localparam logic [7:0] OFF_AUX_B   = 8'h20;
  localparam logic [7:0] OFF_CAPTURE_RELOAD_REG  = 8'h24;
  localparam logic [7:0] OFF_CTRL_B  = 8'h28;
  localparam logic [7:0] OFF_CFG_B   = 8'h2c;

  // Core control fields (both cores)
  localparam int CTL_PRE_LSB  = 0;
  localparam int CTL_MODE_LSB = 3;
  localparam int CTL_RUN      = 6;
  localparam int CTL_DIR      = 7;
  localparam int CTL_DIR_EN   = 8;
  localparam int CTL_LATCH    = 9;
  localparam int CTL_OE       = 10;
  localparam int CTL_CAP_EN   = 11;
  localparam int CTL_CAP_CLR  = 12;

  // Flag bit positions
  localparam int FLG_CORE_A = 0;
  localparam int FLG_AUX_A1 = 1;
  localparam int FLG_AUX_A2 = 2;
  localparam int FLG_CORE_B = 3;
  localparam int FLG_AUX_B  = 4;

  localparam logic [15:0] RST_VAL   = 16'h0000;
  localparam logic [15:0] CNT_MAX   = 16'hffff;
  localparam logic [9:0]  PRE_BASE  = 10'h004;
  localparam logic [1:0]  RESP_OK   = 2'h0;
  localparam logic [1:0]  RESP_ERR  = 2'h2;

  typedef enum logic [2:0] {
    MODE_TIMER   = 3'h0,
    MODE_COUNTER = 3'h1,
    MODE_RELOAD  = 3'h4,
    MODE_CAPTURE = 3'h5
  } mode_e;

  // Low byte of an auxiliary config register
  typedef struct packed {
    logic       dir;
    logic       run;
    logic [2:0] mode;
    logic [2:0] isel;
  } aux_cfg_s;

  typedef struct packed {
    logic rise;
    logic fall;
  } edge_s;

  // Divider mask for a period of 4 * 2^k clocks
  function automatic logic [9:0] pre_mask(input logic [2:0] k);
    pre_mask = (PRE_BASE << k) - 10'h001;
  endfunction

endpackage

/* sim/gp_timer_aux_core_modes_tb.sv */
`timescale 1ns/1ps
module gp_timer_aux_core_modes_tb;
  logic        aclk = 0;
  logic        aresetn = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0;
  logic [3:0]  wstrb = 4'hf;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, rsp;
  logic [31:0] rdata, v, u;
  logic        in_a1 = 0, in_a2 = 0, cnt_in = 0, dir_in = 0;
  logic        out_a, ovf_b;
  int          error_cnt = 0, n_checks = 0, cyc = 0, n_ovf = 0;
  int          hi_len = 0, lo_len = 0, last_hi = 0, last_lo = 0;

  gp_timer_aux_core_modes dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .aux_a1_input_line(in_a1),
    .aux_a2_input_line(in_a2), .core_a_count_input(cnt_in), .core_a_direction_input(dir_in),
    .core_a_output_line(out_a), .core_b_overflow_line(ovf_b));

  always #10 aclk = ~aclk;

  // Whole run needs about 600 cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (ovf_b === 1'b1) n_ovf <= n_ovf + 1;
    // Length of the last complete high and low pulse on the output line
    hi_len <= (out_a === 1'b1) ? hi_len + 1 : 0;
    lo_len <= (out_a === 1'b0) ? lo_len + 1 : 0;
    if (out_a === 1'b0 && hi_len > 0) last_hi <= hi_len;
    if (out_a === 1'b1 && lo_len > 0) last_lo <= lo_len;
    if (cyc == 5000) begin
      error_cnt++;
      conclude();
    end
  end

  task conclude;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Readies sampled at the edge, before the slave's own updates land
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    do begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) awvalid <= 0;
      if (wvalid && wready === 1'b1) wvalid <= 0;
    end while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 0;
  endtask

  task rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 0;
    end while (rvalid !== 1'b1);
    v = rdata;
    rsp = rresp;
    rready <= 0;
  endtask

  task rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(nm, v, e);
  endtask

  task clk(input int n);
    repeat (n) @(posedge aclk);
  endtask

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    rc("core_a", 8'h00, 0);
    rc("ctrl_b", 8'h28, 0);
    rc("flags", 8'h18, 0);
    rd(8'h30);
    chk("rresp", 32'(rsp), 2);
    chk("rdata", v, 0);
    wr(8'h30, 1);
    chk("bresp", 32'(rsp), 2);
    $display("test reset done");
    // Reload from aux A1 on rising input, aux run flag set
    wr(8'h10, 32'h61); wr(8'h04, 32'h1234);
    // each pin level held six clocks
    @(posedge aclk); in_a1 <= 1; clk(6);
    rc("core_a", 8'h00, 32'h1234);
    rc("aux_a1", 8'h04, 32'h1234);
    rc("flags", 8'h18, 32'h2);
    wr(8'h18, 32'h1f);
    $display("test reload done");
    // Select 110: top bit must be ignored, so falling edge only
    wr(8'h14, 32'h6e); wr(8'h08, 1); wr(8'h00, 32'h5a5a);
    @(posedge aclk); in_a2 <= 1; clk(6);
    rc("aux_a2", 8'h08, 1);
    @(posedge aclk); in_a2 <= 0; clk(6);
    rc("aux_a2", 8'h08, 32'h5a5a);
    rc("flags", 8'h18, 32'h4);
    wr(8'h18, 32'h1f);
    $display("test capture done");
    wr(8'h10, 32'h27); wr(8'h14, 32'h27); wr(8'h04, 32'h1111); wr(8'h08, 32'hfff8);
    wr(8'h00, 32'hfffc); wr(8'h0c, 32'h600); clk(3);
    chk("out_a", 32'(out_a), 1);
    rc("core_a", 8'h00, 32'hfffc);
    wr(8'h0c, 32'h200); clk(3);
    chk("out_a", 32'(out_a), 0);
    wr(8'h0c, 32'h240); clk(20); wr(8'h0c, 0);
    rd(8'h00);
    chk("reload_a2", 32'(v >= 32'hfff8 && v <= 32'hffff), 1);
    rd(8'h18);
    chk("flag_core_a", 32'(v[0]), 1);
    wr(8'h18, 32'h1f);
    $display("test latch reload done");
    // Aux A1 down on both edges, aux A2 up on rising edge only
    wr(8'h04, 0); wr(8'h08, 0); wr(8'h10, 32'hcf); wr(8'h14, 32'h4d);
    wr(8'h00, 32'hfffe); wr(8'h0c, 32'h40); clk(20);
    wr(8'h00, 32'hfffe); clk(20); wr(8'h0c, 0);
    rc("aux_a1", 8'h04, 32'hfffe);
    rc("aux_a2", 8'h08, 1);
    $display("test concat done");
    // PWM: A1 reloads on rising latch edge (high time), A2 on falling (low time)
    wr(8'h04, 32'hfffc); wr(8'h08, 32'hfff8); wr(8'h10, 32'h25); wr(8'h14, 32'h26);
    wr(8'h00, 32'hfffe); wr(8'h0c, 32'h440); clk(150);
    chk("pwm_high", last_hi, 16);
    chk("pwm_low", last_lo, 32);
    wr(8'h0c, 0);
    $display("test pwm done");
    wr(8'h1c, 32'hfffc); wr(8'h28, 32'h40); clk(40);
    rc("ctrl_b", 8'h28, 32'h240);
    wr(8'h28, 32'h200);
    rd(8'h1c);
    chk("core_b_up", 32'(v < 32'h10), 1);
    chk("ovf_b", n_ovf, 1);
    u = v;
    clk(10);
    rc("core_b_stop", 8'h1c, u);
    rd(8'h18);
    chk("flag_core_b", 32'(v[3]), 1);
    wr(8'h1c, 32'h2); wr(8'h28, 32'h2c0); clk(40);
    rc("ctrl_b", 8'h28, 32'h0c0);
    wr(8'h28, 0);
    rd(8'h1c);
    chk("core_b_dn", 32'(v > 32'hfff0 && v <= 32'hffff), 1);
    chk("ovf_b", n_ovf, 2);
    $display("test core b done");
    wr(8'h20, 32'h777); wr(8'h28, 32'h1800);
    @(posedge aclk); cnt_in <= 1; clk(6);
    rc("capture_reload_reg", 8'h24, 32'h777);
    rc("aux_b", 8'h20, 0);
    wr(8'h20, 32'h55);
    @(posedge aclk); dir_in <= 1; clk(6);
    rc("capture_reload_reg", 8'h24, 32'h55);
    $display("test aux b capture done");
    conclude();
  end
endmodule // gp_timer_aux_core_modes_tb
